// ==== verilog/smac_access_ctl.sv ====
// SMM RAM access control: the two control registers and the request router.
`timescale 1ns/1ns
`default_nettype none
`include "smac_params.svh"
module smac_access_ctl
    import smac_pkg::*;
#(
    parameter int ADDR_W = 32
) (
    // Clock and synchronous reset.
    input  wire logic              clk_sys,
    input  wire logic              srst,
    // Configuration space port.
    input  wire logic              cfgWrEn,
    input  wire logic              cfgRdEn,
    input  wire logic [7:0]        cfgAddr,
    input  wire logic [7:0]        cfgWrData,
    output logic [7:0]             cfgRdData,
    output logic                   cfgRdValid,
    // Host request.
    input  wire logic              hostAddrStrobe,
    input  wire logic [ADDR_W-1:0] hostAddr,
    input  wire logic              hostSmm,
    input  wire logic              hostCodeRef,
    input  wire logic [ADDR_W-1:0] topOfUsedDram,
    // Routing answer.
    output logic                   routeValid,
    output smac_route_e            routeTarget,
    output logic [ADDR_W-1:0]      dramAddr
);
    ////////////////////////////////////////////////////////////////////////////////
    // Elaboration check.

    // The window constants are 32-bit host addresses.
    if (ADDR_W != 32) begin : g_bad_width
        $error("smac_access_ctl supports only ADDR_W of 32");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations.

    logic              openR;
    logic              closedR;
    logic              lockR;
    logic              globalEnR;
    logic              highEnR;
    logic [1:0]        tsegSizeR;
    logic              tsegEnR;
    logic              invalidFlagR;
    logic              smmCtlWr;
    logic              extCtlWr;
    logic              lockEff;
    logic              openEff;
    logic              closedEff;
    logic              highOn;
    logic              tsegOn;
    logic              visCompat;
    logic              visHigh;
    logic              flagSet;
    logic              inCompat;
    logic              inHigh;
    logic              inTseg;
    logic              tsegSizeOk;
    logic [7:0]        smmCtlVal;
    logic [7:0]        extCtlVal;
    smac_route_e       routeNxt;
    logic [ADDR_W-1:0] addrNxt;

    ////////////////////////////////////////////////////////////////////////////////
    // Control qualification.

    // Register selects.
    assign smmCtlWr  = cfgWrEn && (cfgAddr == `SMAC_OFS_SMM_CTL);
    assign extCtlWr  = cfgWrEn && (cfgAddr == `SMAC_OFS_EXT_CTL);

    // Open, closed and lock mean nothing until the global enable is on.
    assign lockEff   = globalEnR && lockR;
    assign openEff   = globalEnR && openR && !lockR;
    assign closedEff = globalEnR && closedR;
    assign highOn    = globalEnR && highEnR;
    assign tsegOn    = globalEnR && tsegEnR && tsegSizeOk;

    ////////////////////////////////////////////////////////////////////////////////
    // smm_ram_control register.

    // Lock is sticky until reset once the global enable is on; while locked only the closed control stays writable,
    // since the lock is meant to guard placement and visibility, not display access.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            openR     <= 1'b0;
            closedR   <= 1'b0;
            lockR     <= 1'b0;
            globalEnR <= 1'b0;
        end else if (smmCtlWr && !lockEff) begin
            closedR   <= cfgWrData[`SMAC_BIT_CLS];
            lockR     <= cfgWrData[`SMAC_BIT_LCK];
            globalEnR <= cfgWrData[`SMAC_BIT_GEN];
            // Setting lock drops open in the same write.
            openR     <= cfgWrData[`SMAC_BIT_LCK] ? 1'b0 : cfgWrData[`SMAC_BIT_OPEN];
        end else if (smmCtlWr) begin
            closedR   <= cfgWrData[`SMAC_BIT_CLS];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // extended_smm_ram_control register.

    // High enable, size and segment enable freeze under lock.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            highEnR   <= 1'b0;
            tsegSizeR <= `SMAC_TSZ_RSV0;
            tsegEnR   <= 1'b0;
        end else if (extCtlWr && !lockEff) begin
            highEnR   <= cfgWrData[`SMAC_BIT_HEN];
            tsegSizeR <= cfgWrData[`SMAC_BIT_TSZ_HI:`SMAC_BIT_TSZ_LO];
            tsegEnR   <= cfgWrData[`SMAC_BIT_TEN];
        end
    end

    // Invalid-access flag: a new intrusion in the clearing cycle keeps it set.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            invalidFlagR <= 1'b0;
        end else if (flagSet) begin
            invalidFlagR <= 1'b1;
        end else if (extCtlWr && cfgWrData[`SMAC_BIT_ERR]) begin
            invalidFlagR <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register read-back.

    // Fixed fields are built in here rather than stored, so they cannot drift.
    assign smmCtlVal = {1'b0, openR, closedR, lockR, globalEnR, `SMAC_BASE_SEG};
    assign extCtlVal = {highEnR, invalidFlagR, `SMAC_CACHE_BITS, tsegSizeR, tsegEnR};

    // Read data is registered; unmapped offsets read zero.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cfgRdValid <= 1'b0;
            cfgRdData  <= `SMAC_RD_UNMAPPED;
        end else begin
            cfgRdValid <= cfgRdEn;
            if (cfgRdEn) begin
                if (cfgAddr == `SMAC_OFS_SMM_CTL) begin
                    cfgRdData <= smmCtlVal;
                end else if (cfgAddr == `SMAC_OFS_EXT_CTL) begin
                    cfgRdData <= extCtlVal;
                end else begin
                    cfgRdData <= `SMAC_RD_UNMAPPED;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Request routing.

    // Window decoder.
    smac_window_decode #(
        .ADDR_W         (ADDR_W)
    ) u_decode (
        .addr           (hostAddr),
        .topOfUsedDram  (topOfUsedDram),
        .topSegmentSize (tsegSizeR),
        .inCompat       (inCompat),
        .inHigh         (inHigh),
        .inTseg         (inTseg),
        .tsegSizeOk     (tsegSizeOk)
    );

    // Visibility: closed only stops data references, and only in the compatible window.
    assign visCompat = globalEnR && ((hostSmm && !(closedEff && !hostCodeRef)) || openEff);
    assign visHigh   = hostSmm || openEff;

    // A non-SMM touch of the high or top window with open clear is an intrusion.
    assign flagSet = hostAddrStrobe && !hostSmm && !openEff &&
                     ((inHigh && highOn) || (inTseg && tsegOn));

    // Route choice. The compatible window is never relocated, so DRAM sees the host address.
    always_comb begin
        routeNxt = SMAC_ROUTE_PASS;
        addrNxt  = hostAddr;
        if (inCompat) begin
            // A refused compatible access falls back to the legacy video path.
            routeNxt = visCompat ? SMAC_ROUTE_DRAM : SMAC_ROUTE_VIDEO;
        end else if (inHigh && highOn) begin
            if (visHigh) begin
                routeNxt = SMAC_ROUTE_DRAM;
                addrNxt  = `SMAC_COMPAT_LO | (hostAddr & `SMAC_HIGH_MASK);
            end else begin
                routeNxt = SMAC_ROUTE_HUB;
            end
        end else if (inTseg && tsegOn) begin
            // Open does not admit non-SMM requests to the top segment.
            routeNxt = hostSmm ? SMAC_ROUTE_DRAM : SMAC_ROUTE_HUB;
        end
    end

    // Answer register: one cycle after the strobe; target and address hold until the next.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            routeValid  <= 1'b0;
            routeTarget <= SMAC_ROUTE_PASS;
            dramAddr    <= '0;
        end else begin
            routeValid <= hostAddrStrobe;
            if (hostAddrStrobe) begin
                routeTarget <= routeNxt;
                dramAddr    <= addrNxt;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    sequence s_high_intrude;
        hostAddrStrobe && inHigh && highOn && !hostSmm && !openEff;
    endsequence

    sequence s_tseg_nonsmm;
        hostAddrStrobe && inTseg && tsegOn && !hostSmm && !inCompat && !inHigh;
    endsequence

    sequence s_lock_write;
        smmCtlWr && !lockEff && cfgWrData[`SMAC_BIT_LCK];
    endsequence

    a_reset_defaults: assert property ($past(srst) |->
        smmCtlVal == `SMAC_SMM_CTL_RST && extCtlVal == `SMAC_EXT_CTL_RST)
        else $error("control registers not at defaults after reset");

    a_lock_clears_open: assert property (s_lock_write |=> !openR && lockR ##1 lockR)
        else $error("lock write did not clear open or keep lock");

    a_lock_freezes_ext: assert property (lockEff |=> $stable(highEnR) && $stable(tsegSizeR)
        && $stable(tsegEnR) && $stable(openR) && lockR)
        else $error("locked field changed");

    a_gen_read_only: assert property (lockEff |=> globalEnR)
        else $error("global enable changed under lock");

    a_gen_gates_open: assert property (hostAddrStrobe && inCompat && !globalEnR
        |=> routeValid && routeTarget == SMAC_ROUTE_VIDEO)
        else $error("compatible window reached DRAM without global enable");

    a_closed_data_block: assert property (hostAddrStrobe && inCompat && closedEff
        && !hostCodeRef && !openEff |=> routeTarget == SMAC_ROUTE_VIDEO)
        else $error("closed control let a data reference through");

    a_high_intrude: assert property (s_high_intrude |=> routeTarget == SMAC_ROUTE_HUB
        && invalidFlagR)
        else $error("high window intrusion not sent to hub or not flagged");

    a_high_remap: assert property (hostAddrStrobe && inHigh && highOn && hostSmm
        |=> routeTarget == SMAC_ROUTE_DRAM && dramAddr[31:17] == `SMAC_COMPAT_LO >> 17)
        else $error("high window not redirected to the compatible DRAM range");

    a_tseg_nonsmm_hub: assert property (s_tseg_nonsmm |=> routeTarget == SMAC_ROUTE_HUB)
        else $error("non-SMM request reached the top segment DRAM");

    a_flag_sticky: assert property (invalidFlagR && !(extCtlWr && cfgWrData[`SMAC_BIT_ERR])
        |=> invalidFlagR)
        else $error("invalid-access flag dropped without a clearing write");

    a_fixed_fields: assert property (cfgRdEn && cfgAddr == `SMAC_OFS_SMM_CTL
        |=> cfgRdValid && cfgRdData[2:0] == `SMAC_BASE_SEG)
        else $error("base segment field not 010");

    a_cache_bits: assert property (cfgRdEn && cfgAddr == `SMAC_OFS_EXT_CTL
        |=> cfgRdData[5:3] == `SMAC_CACHE_BITS)
        else $error("cache indicator bits not all ones");
endmodule
`default_nettype wire

// ==== verilog/smac_params.svh ====
// Constants for the SMM RAM access control block.
`ifndef SMAC_PARAMS_SVH
`define SMAC_PARAMS_SVH

// Register offsets and reset values.
`define SMAC_OFS_SMM_CTL    8'h9D
`define SMAC_OFS_EXT_CTL    8'h9E
`define SMAC_SMM_CTL_RST    8'h02
`define SMAC_EXT_CTL_RST    8'h38
`define SMAC_RD_UNMAPPED    8'h00

// Field positions in the smm_ram_control register.
`define SMAC_BIT_OPEN       6
`define SMAC_BIT_CLS        5
`define SMAC_BIT_LCK        4
`define SMAC_BIT_GEN        3
`define SMAC_BASE_SEG       3'h2

// Field positions in the extended_smm_ram_control register.
`define SMAC_BIT_HEN        7
`define SMAC_BIT_ERR        6
`define SMAC_CACHE_BITS     3'h7
`define SMAC_BIT_TSZ_HI     2
`define SMAC_BIT_TSZ_LO     1
`define SMAC_BIT_TEN        0
`define SMAC_TSZ_RSV0       2'h0
`define SMAC_TSZ_RSV1       2'h1
`define SMAC_TSZ_512K       2'h2
`define SMAC_TSZ_1M         2'h3

// Address windows.
`define SMAC_COMPAT_LO      32'h000A_0000
`define SMAC_COMPAT_HI      32'h000B_FFFF
`define SMAC_HIGH_LO        32'hFEDA_0000
`define SMAC_HIGH_HI        32'hFEDB_FFFF
`define SMAC_HIGH_MASK      32'h0001_FFFF
`define SMAC_LEN_512K       32'h0008_0000
`define SMAC_LEN_1M         32'h0010_0000
`define SMAC_LEN_NONE       32'h0000_0000

`endif

// ==== verilog/smac_pkg.sv ====
// Types shared by the SMM RAM access control modules.
`default_nettype none
package smac_pkg;
    // Where a host request is sent.
    typedef enum logic [1:0] {
        SMAC_ROUTE_PASS  = 2'b00,
        SMAC_ROUTE_DRAM  = 2'b01,
        SMAC_ROUTE_HUB   = 2'b10,
        SMAC_ROUTE_VIDEO = 2'b11
    } smac_route_e;

    // Inclusive range test on a 32-bit address.
    function automatic logic smac_in_range(input logic [31:0] a,
                                           input logic [31:0] lo,
                                           input logic [31:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction
endpackage
`default_nettype wire

// ==== verilog/smac_window_decode.sv ====
// Address window decoder for the compatible, high and top-segment ranges.
`timescale 1ns/1ns
`default_nettype none
`include "smac_params.svh"
module smac_window_decode
    import smac_pkg::*;
#(
    parameter int ADDR_W = 32
) (
    // Request address and memory top.
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [ADDR_W-1:0] topOfUsedDram,
    input  wire logic [1:0]        topSegmentSize,
    // Window hits.
    output logic                   inCompat,
    output logic                   inHigh,
    output logic                   inTseg,
    output logic                   tsegSizeOk
);
    // The window and length constants are 32-bit host addresses, so no other width fits.
    if (ADDR_W != 32) begin : g_bad_width
        $error("smac_window_decode supports only ADDR_W of 32");
    end

    logic [ADDR_W-1:0] tsegLen;
    logic [ADDR_W-1:0] tsegBase;

    // Size code to length; reserved codes give no segment at all.
    always_comb begin
        unique case (topSegmentSize)
            `SMAC_TSZ_512K: tsegLen = `SMAC_LEN_512K;
            `SMAC_TSZ_1M:   tsegLen = `SMAC_LEN_1M;
            `SMAC_TSZ_RSV0: tsegLen = `SMAC_LEN_NONE;
            `SMAC_TSZ_RSV1: tsegLen = `SMAC_LEN_NONE;
        endcase
    end

    // The segment sits just below the top; a top smaller than the size gives no segment.
    assign tsegSizeOk = (tsegLen != `SMAC_LEN_NONE) && (topOfUsedDram >= tsegLen);
    assign tsegBase   = topOfUsedDram - tsegLen;
    assign inTseg     = tsegSizeOk && (addr >= tsegBase) && (addr < topOfUsedDram);
    assign inCompat   = smac_in_range(addr, `SMAC_COMPAT_LO, `SMAC_COMPAT_HI);
    assign inHigh     = smac_in_range(addr, `SMAC_HIGH_LO, `SMAC_HIGH_HI);
endmodule
`default_nettype wire

// ==== tb/smac_host_model.sv ====
// Host bus model that issues SMM-tagged memory requests to the access control block.
`timescale 1ns/1ns
`default_nettype none
module smac_host_model (
    // Clock.
    input  wire logic        clk_sys,
    // Host request.
    output var logic         hostAddrStrobe,
    output var logic [31:0]  hostAddr,
    output var logic         hostSmm,
    output var logic         hostCodeRef
);
    // The bus starts with everything at zero and later idles with inverted qualifiers, so a stale address never looks valid.
    initial begin
        hostAddrStrobe = 1'b0;
        hostAddr       = 32'h0000_0000;
        hostSmm        = 1'b0;
        hostCodeRef    = 1'b0;
    end

    // One request: strobe for one cycle at a falling edge, then release and invert.
    task automatic issue(input logic [31:0] a, input logic smm, input logic code);
        @(negedge clk_sys);
        hostAddrStrobe = 1'b1;
        hostAddr       = a;
        hostSmm        = smm;
        hostCodeRef    = code;
        @(negedge clk_sys);
        hostAddrStrobe = 1'b0;
        hostAddr       = ~a;
        hostSmm        = ~smm;
        hostCodeRef    = ~code;
    endtask
endmodule
`default_nettype wire

// ==== tb/test_smac_access_ctl.sv ====
// Self-checking testbench for the SMM RAM access control block.
`timescale 1ns/1ns
`default_nettype none
`include "smac_params.svh"
module test_smac_access_ctl;
    import smac_pkg::*;
    logic        clk_sys, srst, cfgWrEn, cfgRdEn, cfgRdValid;
    logic [7:0]  cfgAddr, cfgWrData, cfgRdData;
    logic        hostAddrStrobe, hostSmm, hostCodeRef, routeValid;
    logic [31:0] hostAddr, topOfUsedDram, dramAddr;
    smac_route_e routeTarget;
    int          errCount, samplesChecked;

    smac_access_ctl u_smac_access_ctl (.clk_sys(clk_sys), .srst(srst), .cfgWrEn(cfgWrEn),
        .cfgRdEn(cfgRdEn), .cfgAddr(cfgAddr), .cfgWrData(cfgWrData), .cfgRdData(cfgRdData),
        .cfgRdValid(cfgRdValid), .hostAddrStrobe(hostAddrStrobe), .hostAddr(hostAddr),
        .hostSmm(hostSmm), .hostCodeRef(hostCodeRef), .topOfUsedDram(topOfUsedDram),
        .routeValid(routeValid), .routeTarget(routeTarget), .dramAddr(dramAddr));
    smac_host_model u_smac_host_model (.clk_sys(clk_sys), .hostAddrStrobe(hostAddrStrobe),
        .hostAddr(hostAddr), .hostSmm(hostSmm), .hostCodeRef(hostCodeRef));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock at 4 ns.
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            errCount++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic results;
        $display("Checks %0d, mismatches %0d", samplesChecked, errCount);
        if (errCount == 0 && samplesChecked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Config write: one-cycle strobe launched at a falling edge.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        cfgWrEn = 1'b1;
        cfgAddr = a;
        cfgWrData = d;
        @(negedge clk_sys);
        cfgWrEn = 1'b0;
        cfgWrData = ~d;
    endtask

    // Config read: the answer pulse is looked at in the one cycle it stands.
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk_sys);
        cfgRdEn = 1'b1;
        cfgAddr = a;
        @(negedge clk_sys);
        cfgRdEn = 1'b0;
        check(32'(cfgRdValid), 32'h1);
        check(32'(cfgRdData), 32'(exp));
    endtask

    // Host request and its routing answer one cycle later.
    task automatic rt(input logic [31:0] a, input logic smm, input logic code,
                      input smac_route_e t, input logic [31:0] da);
        u_smac_host_model.issue(a, smm, code);
        check(32'(routeValid), 32'h1);
        check(32'(routeTarget), 32'(t));
        if (t == SMAC_ROUTE_DRAM)
            check(dramAddr, da);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_defaults;
        rd(8'h9D, 8'h02);
        rd(8'h9E, 8'h38);
        rd(8'h9F, 8'h00);
    endtask

    // Controls set while the global enable is off must have no effect.
    task automatic t_global_off;
        wr(8'h9E, 8'h80);
        wr(8'h9D, 8'h40);
        rt(32'h000A_0000, 1'b1, 1'b0, SMAC_ROUTE_VIDEO, 0);
        rt(32'h000A_0010, 1'b0, 1'b0, SMAC_ROUTE_VIDEO, 0);
        rt(32'hFEDA_0000, 1'b1, 1'b0, SMAC_ROUTE_PASS, 0);
        wr(8'h9E, 8'h00);
    endtask

    task automatic t_compat;
        wr(8'h9D, 8'h08);
        rd(8'h9D, 8'h0A);
        rt(32'h000B_FFFF, 1'b1, 1'b0, SMAC_ROUTE_DRAM, 32'h000B_FFFF);
        rt(32'h000A_0000, 1'b0, 1'b0, SMAC_ROUTE_VIDEO, 0);
        rt(32'h000C_0000, 1'b1, 1'b0, SMAC_ROUTE_PASS, 0);
        wr(8'h9D, 8'h48);
        rt(32'h000A_1000, 1'b0, 1'b0, SMAC_ROUTE_DRAM, 32'h000A_1000);
        wr(8'h9D, 8'h28);
        rt(32'h000A_2000, 1'b1, 1'b0, SMAC_ROUTE_VIDEO, 0);
        rt(32'h000A_2000, 1'b1, 1'b1, SMAC_ROUTE_DRAM, 32'h000A_2000);
    endtask

    // High window remap, its boundaries and the sticky invalid flag.
    task automatic t_high;
        wr(8'h9E, 8'h80);
        rt(32'hFEDA_0040, 1'b1, 1'b0, SMAC_ROUTE_DRAM, 32'h000A_0040);
        wr(8'h9D, 8'h08);
        rt(32'hFEDA_1234, 1'b1, 1'b0, SMAC_ROUTE_DRAM, 32'h000A_1234);
        rt(32'hFEDB_FFFF, 1'b1, 1'b1, SMAC_ROUTE_DRAM, 32'h000B_FFFF);
        rt(32'hFEDC_0000, 1'b1, 1'b0, SMAC_ROUTE_PASS, 0);
        rt(32'hFEDA_0000, 1'b0, 1'b0, SMAC_ROUTE_HUB, 0);
        rd(8'h9E, 8'hF8);
        rd(8'h9E, 8'hF8);
        wr(8'h9E, 8'hC0);
        rd(8'h9E, 8'hB8);
        wr(8'h9D, 8'h48);
        rt(32'hFEDA_0010, 1'b0, 1'b0, SMAC_ROUTE_DRAM, 32'h000A_0010);
        rd(8'h9E, 8'hB8);
        wr(8'h9D, 8'h08);
    endtask

    // Top segment below a 256 MB memory top, size codes 512K, 1M and reserved 01.
    task automatic t_tseg;
        wr(8'h9E, 8'h05);
        rt(32'h0FF8_0000, 1'b1, 1'b0, SMAC_ROUTE_DRAM, 32'h0FF8_0000);
        rt(32'h0FF7_FFFF, 1'b1, 1'b0, SMAC_ROUTE_PASS, 0);
        rt(32'h0FFF_FFFF, 1'b0, 1'b1, SMAC_ROUTE_HUB, 0);
        rd(8'h9E, 8'h7D);
        wr(8'h9E, 8'h47);
        rd(8'h9E, 8'h3F);
        rt(32'h0FF0_0000, 1'b1, 1'b0, SMAC_ROUTE_DRAM, 32'h0FF0_0000);
        wr(8'h9D, 8'h48);
        rt(32'h0FF0_0000, 1'b0, 1'b0, SMAC_ROUTE_HUB, 0);
        wr(8'h9E, 8'h03);
        rt(32'h0FFF_0000, 1'b1, 1'b0, SMAC_ROUTE_PASS, 0);
        wr(8'h9E, 8'h04);
        rt(32'h0FFF_0000, 1'b1, 1'b0, SMAC_ROUTE_PASS, 0);
        wr(8'h9D, 8'h00);
        wr(8'h9E, 8'h05);
        rt(32'h0FFF_0000, 1'b0, 1'b0, SMAC_ROUTE_PASS, 0);
    endtask

    // Open is set, then cleared before lock is set, as software must do.
    task automatic t_lock;
        wr(8'h9E, 8'h85);
        wr(8'h9D, 8'h48);
        wr(8'h9D, 8'h08);
        wr(8'h9D, 8'h18);
        rd(8'h9D, 8'h1A);
        rt(32'h000A_0000, 1'b0, 1'b0, SMAC_ROUTE_VIDEO, 0);
        wr(8'h9D, 8'h40);
        rd(8'h9D, 8'h1A);
        wr(8'h9D, 8'h38);
        rd(8'h9D, 8'h3A);
        wr(8'h9E, 8'h00);
        rd(8'h9E, 8'hBD);
        rt(32'hFEDA_0000, 1'b0, 1'b0, SMAC_ROUTE_HUB, 0);
        wr(8'h9E, 8'h40);
        rd(8'h9E, 8'hBD);
    endtask

    // A second reset in mid-run must undo the lock as well.
    task automatic t_rereset;
        @(negedge clk_sys);
        srst = 1'b1;
        repeat (2) @(negedge clk_sys);
        srst = 1'b0;
        rd(8'h9D, 8'h02);
        rd(8'h9E, 8'h38);
        rt(32'h000A_0000, 1'b1, 1'b0, SMAC_ROUTE_VIDEO, 0);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence; inputs change only at falling edges.
    initial begin
        errCount = 0;
        samplesChecked = 0;
        srst = 1'b1;
        cfgWrEn = 1'b0;
        cfgRdEn = 1'b0;
        cfgAddr = 8'h00;
        cfgWrData = 8'h00;
        topOfUsedDram = 32'h1000_0000;
        repeat (12) @(negedge clk_sys);
        srst = 1'b0;
        t_defaults();
        t_global_off();
        t_compat();
        t_high();
        t_tseg();
        t_lock();
        t_rereset();
        results();
    end

    // Watchdog: the whole sequence needs well under a thousand cycles.
    initial begin
        repeat (2000) @(posedge clk_sys);
        errCount++;
        results();
    end
endmodule
`default_nettype wire
